// ==== common/pial_consts.svh ====
// Constants for the identifier and auto-negotiation ability registers.
// Summary of operation
// - Index 2 holds identifier bits three to eighteen.
// - Index 3 bits 15:10 hold identifier bits 19-24.
// - Model number 9:4, revision number 3:0.
// - Revision follows silicon, not a constant.
// - Next page and remote fault writable, reset zero.
// - Advertised pause field encoding, reset none.
// - Both pause advertised resolves to one mode.
// - Bits 8..5 advertise local speed abilities.
// - Straps load bits 8,6,5; bit 7 resets one.
// - Partner register read-only; acknowledge marks received word.
// - Partner pause support bits, reset zero.
// - Partner T4 reported; local never supports T4.
// - Partner ability bits reset to zero.
// - Abilities apply only while auto-negotiation enabled.
`ifndef PIAL_CONSTS_SVH
`define PIAL_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define PIAL_IDX_IDENT_HI 8'h02
`define PIAL_IDX_IDENT_LO 8'h03
`define PIAL_IDX_ADV 8'h04
`define PIAL_IDX_PARTNER 8'h05
`define PIAL_IDX_CTRL 8'h10
`define PIAL_IDX_STAT 8'h11
`define PIAL_IDX 9:2
`define PIAL_ADDR_MIN 10

// Field positions.
`define PIAL_OUI_LO 15:10
`define PIAL_MODEL 9:4
`define PIAL_REV 3:0
`define PIAL_NP 15
`define PIAL_ACK 14
`define PIAL_RF 13
`define PIAL_PAUSE 11:10
`define PIAL_T4 9
`define PIAL_FD100 8
`define PIAL_HD100 7
`define PIAL_FD10 6
`define PIAL_HD10 5
`define PIAL_SEL 4:0
`define PIAL_AN_EN 12
`define PIAL_SPEED 13
`define PIAL_DUPLEX 8
`define PIAL_ST_VALID 0
`define PIAL_ST_SPEED 1
`define PIAL_ST_DUPLEX 2
`define PIAL_ST_PAUSE 4:3
`define PIAL_STRAP_FD100 2
`define PIAL_STRAP_FD10 1
`define PIAL_STRAP_HD10 0

// Reset values and write masks.
`define PIAL_ADV_RST 16'h0081
`define PIAL_PART_RST 16'h0001
`define PIAL_CTRL_RST 16'h3000
`define PIAL_REV_PRE 4'h0
`define PIAL_ADV_WMASK 16'hADFF
`define PIAL_PART_MASK 16'hEFFF
`define PIAL_CTRL_WMASK 16'h3100
`define PIAL_ALL16 16'hFFFF
`define PIAL_ZERO16 16'h0000

// Pause field codes.
`define PIAL_PAUSE_SYM 2'h1
`define PIAL_PAUSE_ASYM 2'h2
`define PIAL_PAUSE_BOTH 2'h3

// Bus response codes.
`define PIAL_RESP_OKAY 2'h0
`define PIAL_RESP_SLVERR 2'h2

`endif

// ==== common/pial_pkg.sv ====
// Types shared by the ability register block and its resolver.
package pial_pkg;

   typedef enum logic [1:0] {
      pause_off,
      pause_sym,
      pause_asym_rx,
      pause_asym_tx
   } pial_pause_e;

   typedef struct packed {
      logic valid;
      logic speed100;
      logic full_dup;
      pial_pause_e pause;
   } pial_res_s;

   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } pial_page_s;

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_idx;
      logic w_held;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic loaded;
      logic [15:0] id_high;
      logic [15:0] id_low;
      logic [15:0] adv;
      logic [15:0] partner;
      logic [15:0] ctrl;
      pial_res_s res;
   } pial_state_s;

endpackage

// ==== design/pial_resolve.sv ====
// Resolves speed, duplex and pause from the two ability words.
`timescale 1ns/1ns
`include "pial_consts.svh"

module pial_resolve (
   // Ability words and control.
   input wire logic [15:0] adv_in,
   input wire logic [15:0] partner_in,
   input wire logic [15:0] ctrl_in,
   input wire logic an_complete_in,
   // Resolved configuration.
   output pial_pkg::pial_res_s res_out
);

   logic [15:0] common;
   logic [1:0] lp;
   logic [1:0] pp;

   // Picks the best common mode, or the manual choice without negotiation.
   always_comb begin
      common = adv_in & partner_in;
      lp = adv_in[`PIAL_PAUSE];
      pp = partner_in[`PIAL_PAUSE];
      res_out = '0;
      res_out.pause = pial_pkg::pause_off;
      if (ctrl_in[`PIAL_AN_EN]) begin
         res_out.valid = an_complete_in;
         if (common[`PIAL_FD100]) begin
            res_out.speed100 = 1'b1;
            res_out.full_dup = 1'b1;
         end else if (common[`PIAL_HD100]) begin
            res_out.speed100 = 1'b1;
         end else if (common[`PIAL_FD10]) begin
            res_out.full_dup = 1'b1;
         end
         // A single pause mode is chosen even when both are offered.
         if (lp[0] && pp[0]) begin
            res_out.pause = pial_pkg::pause_sym;
         end else if (lp == `PIAL_PAUSE_BOTH && pp == `PIAL_PAUSE_ASYM) begin
            res_out.pause = pial_pkg::pause_asym_rx;
         end else if (lp == `PIAL_PAUSE_ASYM && pp == `PIAL_PAUSE_BOTH) begin
            res_out.pause = pial_pkg::pause_asym_tx;
         end
         if (!an_complete_in) begin
            res_out.pause = pial_pkg::pause_off;
         end
      end else begin
         res_out.valid = 1'b1;
         res_out.speed100 = ctrl_in[`PIAL_SPEED];
         res_out.full_dup = ctrl_in[`PIAL_DUPLEX];
      end
   end

endmodule

// ==== design/pial_regs.sv ====
// Identifier and auto-negotiation ability registers behind AXI4-Lite.
`timescale 1ns/1ns
`include "pial_consts.svh"

module pial_regs #(
   parameter int ADDR_W = 12,
   parameter logic [15:0] ID_HIGH_RST = 16'h1234, // Arbitrary value.
   parameter logic [5:0] OUI_LOW_RST = 6'h2A, // Arbitrary value.
   parameter logic [5:0] MODEL_RST = 6'h15 // Arbitrary value.
) (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // AXI4-Lite write address and data.
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [ADDR_W-1:0] awaddr_in,
   input wire logic wvalid_in,
   output logic wready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   // AXI4-Lite write response.
   output logic bvalid_out,
   input wire logic bready_in,
   output logic [1:0] bresp_out,
   // AXI4-Lite read.
   input wire logic arvalid_in,
   output logic arready_out,
   input wire logic [ADDR_W-1:0] araddr_in,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   // Straps and silicon revision, caught after reset release.
   input wire logic [2:0] strap_ability_in,
   input wire logic [3:0] silicon_rev_in,
   // Link side: received base page and negotiation progress.
   input wire pial_pkg::pial_page_s page_in,
   input wire logic an_complete_in,
   // Configuration toward the link logic.
   output logic [15:0] adv_word_out,
   output logic an_enable_out,
   output pial_pkg::pial_res_s res_out
);

   pial_pkg::pial_state_s st_reg;
   pial_pkg::pial_state_s st_next;
   pial_pkg::pial_res_s res_w;
   logic [15:0] rd_word;
   logic rd_ok;
   logic wr_ok;

   // Refuses address widths too narrow to reach every register.
   if (ADDR_W < `PIAL_ADDR_MIN) begin
      $error("ADDR_W too narrow for the register map.");
   end

   // Merges a write into a register through byte strobes and a mask.
   function automatic logic [15:0] wmerge(
      input logic [15:0] old,
      input logic [15:0] data,
      input logic [1:0] strb,
      input logic [15:0] mask
   );
      logic [15:0] be;
      be = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~be) | (data & be);
   endfunction

   // Tells whether an index names a mapped register.
   function automatic logic mapped(input logic [7:0] idx);
      logic hit;
      case (idx)
         `PIAL_IDX_IDENT_HI, `PIAL_IDX_IDENT_LO, `PIAL_IDX_ADV,
         `PIAL_IDX_PARTNER, `PIAL_IDX_CTRL, `PIAL_IDX_STAT: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   // Resolves the working link configuration.
   pial_resolve u_resolve (
      .adv_in(st_reg.adv),
      .partner_in(st_reg.partner),
      .ctrl_in(st_reg.ctrl),
      .an_complete_in(an_complete_in),
      .res_out(res_w)
   );

   // Selects the read word for the requested index.
   always_comb begin
      rd_word = `PIAL_ZERO16;
      rd_ok = mapped(araddr_in[`PIAL_IDX]);
      case (araddr_in[`PIAL_IDX])
         `PIAL_IDX_IDENT_HI: begin
            rd_word = st_reg.id_high;
         end
         `PIAL_IDX_IDENT_LO: begin
            rd_word = st_reg.id_low;
         end
         `PIAL_IDX_ADV: begin
            rd_word = st_reg.adv;
         end
         `PIAL_IDX_PARTNER: begin
            rd_word = st_reg.partner;
         end
         `PIAL_IDX_CTRL: begin
            rd_word = st_reg.ctrl;
         end
         `PIAL_IDX_STAT: begin
            rd_word[`PIAL_ST_VALID] = st_reg.res.valid;
            rd_word[`PIAL_ST_SPEED] = st_reg.res.speed100;
            rd_word[`PIAL_ST_DUPLEX] = st_reg.res.full_dup;
            rd_word[`PIAL_ST_PAUSE] = st_reg.res.pause;
         end
         default: begin
            rd_word = `PIAL_ZERO16;
         end
      endcase
   end

   // Handshake outputs stay combinational; one transfer each way at a time.
   assign awready_out = !st_reg.aw_held && !st_reg.bvalid;
   assign wready_out = !st_reg.w_held && !st_reg.bvalid;
   assign arready_out = !st_reg.rvalid;
   assign wr_ok = mapped(st_reg.aw_idx);

   // Computes the next state of the whole block.
   always_comb begin
      st_next = st_reg;
      // Straps and revision are caught on the first edge after reset.
      if (!st_reg.loaded) begin
         st_next.loaded = 1'b1;
         st_next.id_low[`PIAL_REV] = silicon_rev_in;
         st_next.adv[`PIAL_FD100] = strap_ability_in[`PIAL_STRAP_FD100];
         st_next.adv[`PIAL_FD10] = strap_ability_in[`PIAL_STRAP_FD10];
         st_next.adv[`PIAL_HD10] = strap_ability_in[`PIAL_STRAP_HD10];
      end
      if (awvalid_in && awready_out) begin
         st_next.aw_held = 1'b1;
         st_next.aw_idx = awaddr_in[`PIAL_IDX];
      end
      if (wvalid_in && wready_out) begin
         st_next.w_held = 1'b1;
         st_next.wdata = wdata_in[15:0];
         st_next.wstrb = wstrb_in[1:0];
      end
      // A write completes once both address and data are held.
      if (st_reg.aw_held && st_reg.w_held) begin
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = wr_ok ? `PIAL_RESP_OKAY : `PIAL_RESP_SLVERR;
         case (st_reg.aw_idx)
            `PIAL_IDX_IDENT_HI: begin
               st_next.id_high = wmerge(st_reg.id_high, st_reg.wdata,
                  st_reg.wstrb, `PIAL_ALL16);
            end
            `PIAL_IDX_IDENT_LO: begin
               st_next.id_low = wmerge(st_reg.id_low, st_reg.wdata,
                  st_reg.wstrb, `PIAL_ALL16);
            end
            `PIAL_IDX_ADV: begin
               // Reserved bits 14, 12 and 9 stay zero; no T4 offered.
               st_next.adv = wmerge(st_reg.adv, st_reg.wdata,
                  st_reg.wstrb, `PIAL_ADV_WMASK);
            end
            `PIAL_IDX_CTRL: begin
               st_next.ctrl = wmerge(st_reg.ctrl, st_reg.wdata,
                  st_reg.wstrb, `PIAL_CTRL_WMASK);
            end
            default: begin
               st_next.bresp = st_next.bresp; // Read-only or unmapped.
            end
         endcase
      end
      if (st_reg.bvalid && bready_in) begin
         st_next.bvalid = 1'b0;
      end
      // A read is answered one cycle after its address is taken.
      if (arvalid_in && arready_out) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = {16'h0000, rd_word};
         st_next.rresp = rd_ok ? `PIAL_RESP_OKAY : `PIAL_RESP_SLVERR;
      end
      if (st_reg.rvalid && rready_in) begin
         st_next.rvalid = 1'b0;
      end
      // Base page from the partner; acknowledge marks its arrival.
      if (page_in.valid) begin
         st_next.partner = page_in.word & `PIAL_PART_MASK;
         st_next.partner[`PIAL_ACK] = 1'b1;
      end
      st_next.res = res_w;
   end

   // Registers the state; reset takes constants only.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
         st_reg.id_high <= ID_HIGH_RST;
         st_reg.id_low <= {OUI_LOW_RST, MODEL_RST, `PIAL_REV_PRE};
         st_reg.adv <= `PIAL_ADV_RST;
         st_reg.partner <= `PIAL_PART_RST;
         st_reg.ctrl <= `PIAL_CTRL_RST;
         st_reg.res.pause <= pial_pkg::pause_off;
      end else begin
         st_reg <= st_next;
      end
   end

   // Data outputs come straight from the state register.
   assign bvalid_out = st_reg.bvalid;
   assign bresp_out = st_reg.bresp;
   assign rvalid_out = st_reg.rvalid;
   assign rdata_out = st_reg.rdata;
   assign rresp_out = st_reg.rresp;
   assign adv_word_out = st_reg.adv;
   assign an_enable_out = st_reg.ctrl[`PIAL_AN_EN];
   assign res_out = st_reg.res;

   // Revision is taken from the live silicon input at load.
   property p_rev_follow;
      @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(st_reg.loaded) |->
         st_reg.id_low[`PIAL_REV] == $past(silicon_rev_in);
   endproperty
   a_rev_follow: assert property (p_rev_follow)
      else $error("Revision field did not follow silicon input.");

   // Strapped abilities load once; bit 7 is set at load.
   property p_strap_load;
      @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(st_reg.loaded) |->
         st_reg.adv[`PIAL_FD100] ==
            $past(strap_ability_in[`PIAL_STRAP_FD100]) &&
         st_reg.adv[`PIAL_FD10] ==
            $past(strap_ability_in[`PIAL_STRAP_FD10]) &&
         st_reg.adv[`PIAL_HD10] ==
            $past(strap_ability_in[`PIAL_STRAP_HD10]) &&
         st_reg.adv[`PIAL_HD100];
   endproperty
   a_strap_load: assert property (p_strap_load)
      else $error("Strapped abilities not loaded.");

   // A full write to the advertisement lands masked one cycle later.
   property p_adv_write;
      @(posedge mclk_in) disable iff (!rst_n_in)
      st_reg.aw_held && st_reg.w_held && st_reg.aw_idx == `PIAL_IDX_ADV &&
      st_reg.wstrb == 2'h3 && st_reg.loaded |=>
         st_reg.adv == ($past(st_reg.wdata) & `PIAL_ADV_WMASK);
   endproperty
   a_adv_write: assert property (p_adv_write)
      else $error("Advertisement write not stored as masked.");

   // Advertisement bits 9 and 14 are zero whenever a write response is pending.
   property p_adv_reserved;
      @(posedge mclk_in) disable iff (!rst_n_in)
      st_reg.bvalid |-> !st_reg.adv[`PIAL_T4] && !st_reg.adv[14];
   endproperty
   a_adv_reserved: assert property (p_adv_reserved)
      else $error("Reserved advertisement bit set.");

   // A received page is acknowledged and copied on the next edge.
   property p_page_copy;
      @(posedge mclk_in) disable iff (!rst_n_in)
      page_in.valid |=> st_reg.partner[`PIAL_ACK] &&
         st_reg.partner[11:0] == $past(page_in.word[11:0]);
   endproperty
   a_page_copy: assert property (p_page_copy)
      else $error("Partner page not captured.");

   // The partner register changes only with a received page.
   property p_partner_ro;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !page_in.valid |=> $stable(st_reg.partner);
   endproperty
   a_partner_ro: assert property (p_partner_ro)
      else $error("Partner register changed without a page.");

   // Without negotiation the manual speed applies one cycle on.
   property p_manual_speed;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !st_reg.ctrl[`PIAL_AN_EN] |=>
         st_reg.res.speed100 == $past(st_reg.ctrl[`PIAL_SPEED]);
   endproperty
   a_manual_speed: assert property (p_manual_speed)
      else $error("Manual speed not applied.");

   // Symmetric pause needs both sides to offer it.
   property p_pause_one;
      @(posedge mclk_in) disable iff (!rst_n_in)
      st_reg.res.pause == pial_pkg::pause_sym |->
         $past(st_reg.adv[10]) && $past(st_reg.partner[10]);
   endproperty
   a_pause_one: assert property (p_pause_one)
      else $error("Symmetric pause chosen without both offering it.");

   // A taken read address is answered on the next edge.
   property p_read_answer;
      @(posedge mclk_in) disable iff (!rst_n_in)
      arvalid_in && arready_out |=> st_reg.rvalid ##0
         (st_reg.rresp == `PIAL_RESP_OKAY) == $past(rd_ok);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("Read not answered one cycle after address.");

endmodule

// ==== verification/pial_partner.sv ====
// Behavioural link partner that delivers received base pages.
`timescale 1ns/1ns

module pial_partner (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Page request from the bench.
   input wire logic send_in,
   input wire logic [15:0] word_in,
   input wire logic [3:0] gap_in,
   // Received page toward the block.
   output pial_pkg::pial_page_s page_out,
   output logic busy_out
);
   logic [3:0] cnt_reg;
   logic [15:0] word_reg;

   // Waits gap_in cycles, then shows the page for one cycle; the word
   // flips every cycle outside that pulse so a stale word never matches.
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b0;
         cnt_reg <= 4'h0;
         word_reg <= 16'h0000;
         page_out <= '0;
      end else begin
         page_out.valid <= 1'b0;
         page_out.word <= ~page_out.word;
         if (send_in && !busy_out) begin
            busy_out <= 1'b1;
            cnt_reg <= gap_in;
            word_reg <= word_in;
         end else if (busy_out && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end else if (busy_out) begin
            page_out <= '{valid: 1'b1, word: word_reg};
            busy_out <= 1'b0;
         end
      end
   end
endmodule

// ==== verification/tb_pial_regs.sv ====
// Self-checking bench for the identifier and ability register block.
`timescale 1ns/1ns
`include "pial_consts.svh"

`define CHK(nm, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
   end \
end

module tb_pial_regs;
   localparam logic [15:0] ID_HI = 16'h5A3C; // Arbitrary value.
   localparam logic [5:0] OUI = 6'h15; // Arbitrary value.
   localparam logic [5:0] MODEL = 6'h2B; // Arbitrary value.
   localparam logic [1:0] OK = `PIAL_RESP_OKAY;
   localparam logic [1:0] ERR = `PIAL_RESP_SLVERR;
   localparam logic [1:0] LP [7] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h3, 2'h0, 2'h2};
   localparam logic [1:0] PP [7] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3, 2'h2};
   localparam logic [1:0] EP [7] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0};
   logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, an_done, an_en, send, busy;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, srev, gap;
   logic [1:0] bresp, rresp;
   logic [2:0] strap;
   logic [15:0] adv_word, pword;
   pial_pkg::pial_page_s page;
   pial_pkg::pial_res_s res;
   int n_fail = 0;
   int samples_checked = 0;
   int k;

   pial_regs #(.ID_HIGH_RST(ID_HI), .OUI_LOW_RST(OUI), .MODEL_RST(MODEL)) dut (
      .mclk_in(mclk), .rst_n_in(rst_n), .awvalid_in(awvalid),
      .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
      .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb),
      .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
      .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
      .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
      .rresp_out(rresp), .strap_ability_in(strap), .silicon_rev_in(srev),
      .page_in(page), .an_complete_in(an_done), .adv_word_out(adv_word),
      .an_enable_out(an_en), .res_out(res));

   pial_partner link (.mclk_in(mclk), .rst_n_in(rst_n), .send_in(send),
      .word_in(pword), .gap_in(gap), .page_out(page), .busy_out(busy));

   // Free-running 10 MHz clock.
   always #50 mclk = ~mclk;

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Holds reset for 16 cycles, then lets straps and revision load.
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask

   // One bus write; each channel is released at its own handshake.
   task automatic wr(input logic [7:0] i, input logic [15:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      bit a, w, b;
      a = 1;
      w = 1;
      b = 1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {16'h0000, d};
      wstrb <= s;
      while (a || w || b) begin
         @(posedge mclk);
         if (b && bvalid) `CHK("bresp", er, bresp)
         a = a && !awready;
         w = w && !wready;
         b = b && !bvalid;
         awvalid <= a;
         wvalid <= w;
         bready <= b;
      end
      @(posedge mclk);
   endtask

   // One bus read compared against the expected word and response.
   task automatic rc(input logic [7:0] i, input logic [15:0] e,
                     input logic [1:0] er);
      bit a, b;
      a = 1;
      b = 1;
      arvalid <= 1'b1;
      rready <= 1'b1;
      araddr <= {2'h0, i, 2'h0};
      while (a || b) begin
         @(posedge mclk);
         if (b && rvalid) begin
            `CHK("rdata", {16'h0000, e}, rdata)
            `CHK("rresp", er, rresp)
         end
         a = a && !arready;
         b = b && !rvalid;
         arvalid <= a;
         rready <= b;
      end
      @(posedge mclk);
   endtask

   // Asks the partner for a page and waits until the result settles.
   task automatic pg(input logic [15:0] w, input logic [3:0] g);
      send <= 1'b1;
      pword <= w;
      gap <= g;
      @(posedge mclk);
      send <= 1'b0;
      repeat (g + 6) @(posedge mclk);
   endtask

   // Cuts a hung run short.
   initial begin
      repeat (8000) @(posedge mclk);
      n_fail++;
      end_sim();
   end

   // Main test sequence.
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, send, an_done} = '0;
      {awaddr, araddr, wdata, wstrb, pword, gap} = '0;
      strap = 3'h5;
      srev = 4'h9;
      do_reset();
      rc(`PIAL_IDX_IDENT_HI, ID_HI, OK);
      rc(`PIAL_IDX_IDENT_LO, {OUI, MODEL, 4'h9}, OK);
      rc(`PIAL_IDX_ADV, 16'h01A1, OK);
      rc(`PIAL_IDX_PARTNER, 16'h0001, OK);
      `CHK("adv_word", 16'h01A1, adv_word)
      wr(`PIAL_IDX_IDENT_HI, 16'hC3A5, 4'hF, OK);
      rc(`PIAL_IDX_IDENT_HI, 16'hC3A5, OK);
      wr(`PIAL_IDX_IDENT_LO, 16'h5AF0, 4'hF, OK);
      rc(`PIAL_IDX_IDENT_LO, 16'h5AF0, OK);
      wr(`PIAL_IDX_ADV, 16'h0000, 4'h2, OK);
      rc(`PIAL_IDX_ADV, 16'h00A1, OK);
      wr(`PIAL_IDX_ADV, 16'hFFFF, 4'hF, OK);
      rc(`PIAL_IDX_ADV, 16'hADFF, OK);
      `CHK("adv_word", 16'hADFF, adv_word)
      wr(`PIAL_IDX_PARTNER, 16'hFFFF, 4'hF, OK);
      rc(`PIAL_IDX_PARTNER, 16'h0001, OK);
      wr(8'h07, 16'hFFFF, 4'hF, ERR);
      rc(8'h06, 16'h0000, ERR);
      pg(16'hFFFF, 4'h0);
      rc(`PIAL_IDX_PARTNER, 16'hEFFF, OK);
      pg(16'h0000, 4'h5);
      rc(`PIAL_IDX_PARTNER, 16'h4000, OK);
      `CHK("res_valid", 1'b0, res.valid)
      an_done <= 1'b1;
      for (k = 0; k < 7; k++) begin
         wr(`PIAL_IDX_ADV, {4'h0, LP[k], 10'h1E1}, 4'hF, OK);
         pg({4'h0, PP[k], 10'h1E1}, 4'h1);
         `CHK("res_pause", EP[k], res.pause)
         `CHK("res_speed", 1'b1, res.speed100)
      end
      wr(`PIAL_IDX_ADV, 16'h0061, 4'hF, OK);
      `CHK("res_speed", 1'b0, res.speed100)
      `CHK("res_dup", 1'b1, res.full_dup)
      `CHK("res_valid", 1'b1, res.valid)
      wr(`PIAL_IDX_CTRL, 16'h0000, 4'hF, OK);
      `CHK("an_en", 1'b0, an_en)
      `CHK("res_dup", 1'b0, res.full_dup)
      `CHK("res_pause", 2'h0, res.pause)
      rc(`PIAL_IDX_STAT, 16'h0001, OK);
      wr(`PIAL_IDX_CTRL, 16'hEFFF, 4'hF, OK);
      rc(`PIAL_IDX_CTRL, 16'h2100, OK);
      rc(`PIAL_IDX_STAT, 16'h0007, OK);
      `CHK("res_speed", 1'b1, res.speed100)
      `CHK("res_dup", 1'b1, res.full_dup)
      strap <= 3'h2;
      srev <= 4'h6;
      do_reset();
      rc(`PIAL_IDX_IDENT_LO, {OUI, MODEL, 4'h6}, OK);
      rc(`PIAL_IDX_ADV, 16'h00C1, OK);
      rc(`PIAL_IDX_PARTNER, 16'h0001, OK);
      `CHK("an_en", 1'b1, an_en)
      end_sim();
   end
endmodule
